// *** logic/lcd_ram_bank.sv ***
// display RAM write mapping, bank selection and bit framing
`timescale 1ns/100ps
module lcd_ram_bank #(
  parameter int PHASE_CYC = lcd_ram_pkg::MUX_PHASE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial link, open drain data
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // hardware subaddress straps
  input wire logic hw_subaddr_bit0,
  input wire logic hw_subaddr_bit1,
  input wire logic hw_subaddr_bit2,
  // display drive
  output logic [3:0] backplane_output,
  output logic [39:0] segment_output
);
  logic sclS, sdaS, sclD, sdaD;
  logic [2:0] hwSub;
  logic sclRise, sclFall, startCond, stopCond;
  lcd_ram_pkg::i2c_state_t i2cState_r;
  logic [3:0] bitCnt_r;
  logic [1:0] wrRow_r;
  logic [5:0] ptr_r;
  logic [2:0] subCnt_r;
  logic [1:0] mode_r;
  logic inBank_r, outBank_r;
  logic match;
  logic bitTake, advance, bitPend_r, lastBit;
  logic [1:0] lastRow, baseRow, wrRowAbs;
  logic [lcd_ram_pkg::COLS-1:0] ram_r [lcd_ram_pkg::ROWS];
  logic [15:0] divCnt_r;
  logic tick_r;
  logic [1:0] phase_r, nPhaseLast, outRow;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic busWr, busRd;
  logic [31:0] rdMux;

  // straps are sampled continuously; they must not change mid-access
  pin_sync #(.W(5), .INIT(5'h1F)) uLinkSync (
    .core_clk(core_clk),
    .srst(srst),
    .din({scl, sdaIn, hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0}),
    .dout({sclS, sdaS, hwSub})
  );

  // previous synchronised levels for edge finding
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end
    else
    begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // data moving while the clock is high is never a data bit
  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;
  assign startCond = sclS && sclD && sdaD && !sdaS;
  assign stopCond = sclS && sclD && !sdaD && sdaS;

  // only a matching counter lets the device store and acknowledge
  assign match = (subCnt_r == hwSub);
  assign bitTake = (i2cState_r == lcd_ram_pkg::I_BITS) && sclFall && bitPend_r;
  assign lastBit = (bitCnt_r == 4'(lcd_ram_pkg::BITS_PER_BYTE - 4'h1));

  // a bit counts only once its pulse ends; a stop pulse is never stored
  always_ff @(posedge core_clk)
  begin
    if (srst || startCond || stopCond)
    begin
      bitPend_r <= 1'b0;
    end
    else if (sclRise && (i2cState_r == lcd_ram_pkg::I_BITS))
    begin
      bitPend_r <= 1'b1;
    end
    else if (bitTake)
    begin
      bitPend_r <= 1'b0;
    end
  end

  // bits per column follow the drive mode
  always_comb
  begin
    unique case (mode_r)
      lcd_ram_pkg::MODE_STATIC: lastRow = 2'h0;
      lcd_ram_pkg::MODE_DUP: lastRow = 2'h1;
      lcd_ram_pkg::MODE_TRI: lastRow = 2'h2;
      lcd_ram_pkg::MODE_QUAD: lastRow = 2'h3;
    endcase
  end

  // alternate bank only exists in static and 1:2 modes
  assign baseRow = (inBank_r && !mode_r[1]) ? 2'h2 : 2'h0;
  assign wrRowAbs = 2'(baseRow + wrRow_r);

  // eighth bit in 1:3 leaves row 2 free and moves on a column
  assign advance = (wrRow_r == lastRow) ||
                   ((mode_r == lcd_ram_pkg::MODE_TRI) && (bitCnt_r == 4'h7));

  // bit framing: start, eight bits, acknowledge slot
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      i2cState_r <= lcd_ram_pkg::I_IDLE;
      bitCnt_r <= 4'h0;
    end
    else if (startCond)
    begin
      i2cState_r <= lcd_ram_pkg::I_BITS;
      bitCnt_r <= 4'h0;
    end
    else if (stopCond)
    begin
      i2cState_r <= lcd_ram_pkg::I_IDLE;
    end
    else
    begin
      unique case (i2cState_r)
        lcd_ram_pkg::I_IDLE: ;
        lcd_ram_pkg::I_BITS:
        begin
          if (bitTake)
          begin
            bitCnt_r <= 4'(bitCnt_r + 4'h1);
          end
          if (bitTake && lastBit)
          begin
            i2cState_r <= lcd_ram_pkg::I_ACK;
          end
        end
        lcd_ram_pkg::I_ACK:
        begin
          if (sclFall)
          begin
            i2cState_r <= lcd_ram_pkg::I_BITS;
            bitCnt_r <= 4'h0;
          end
        end
      endcase
    end
  end

  // acknowledge pull-down; the line is released after the slot
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sdaOeN <= 1'b1;
      sdaOut <= 1'b0;
    end
    else if (startCond || stopCond)
    begin
      sdaOeN <= 1'b1;
    end
    else if (bitTake && lastBit) // counter not yet bumped by an overflow here
    begin
      sdaOeN <= !match;
    end
    else if (sclFall && (i2cState_r == lcd_ram_pkg::I_ACK))
    begin
      sdaOeN <= 1'b1;
    end
  end

  // write position walks per bit; overflow hands over to the next device
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ptr_r <= lcd_ram_pkg::PTR_RST;
      subCnt_r <= lcd_ram_pkg::SUB_RST;
      wrRow_r <= 2'h0;
    end
    else if (busWr && (wrAddr_r == lcd_ram_pkg::ADDR_PTR))
    begin
      ptr_r <= hwdata[5:0];
      wrRow_r <= 2'h0;
    end
    else if (busWr && (wrAddr_r == lcd_ram_pkg::ADDR_SUB))
    begin
      subCnt_r <= hwdata[2:0];
    end
    else if (startCond || (sclFall && (i2cState_r == lcd_ram_pkg::I_ACK)))
    begin
      wrRow_r <= 2'h0;
    end
    else if (bitTake)
    begin
      if (advance)
      begin
        wrRow_r <= 2'h0;
        if (ptr_r == lcd_ram_pkg::PTR_LAST)
        begin
          ptr_r <= 6'h00;
          subCnt_r <= 3'(subCnt_r + 3'h1);
        end
        else
        begin
          ptr_r <= 6'(ptr_r + 6'h01);
        end
      end
      else
      begin
        wrRow_r <= 2'(wrRow_r + 2'h1);
      end
    end
  end

  // storage; a rewrite at a 1:3 third column fills its row 2
  always_ff @(posedge core_clk)
  begin
    if (bitTake && match)
    begin
      ram_r[wrRowAbs][ptr_r] <= sdaD;
    end
  end

  // multiplex phase enable from the core clock
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      divCnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (divCnt_r == 16'(PHASE_CYC - 1))
    begin
      divCnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      divCnt_r <= 16'(divCnt_r + 16'h0001);
      tick_r <= 1'b0;
    end
  end

  // number of phases per frame equals rows in use
  assign nPhaseLast = lastRow;

  // phase sequence across the multiplex frame
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      phase_r <= 2'h0;
    end
    else if (tick_r)
    begin
      if (phase_r >= nPhaseLast)
      begin
        phase_r <= 2'h0;
      end
      else
      begin
        phase_r <= 2'(phase_r + 2'h1);
      end
    end
  end

  // output bank offset applies only in static and 1:2
  assign outRow = 2'(phase_r + ((outBank_r && !mode_r[1]) ? 2'h2 : 2'h0));

  // display register reloads every cycle so a bank flip shows at once
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      backplane_output <= 4'h0;
      segment_output <= 40'h00_0000_0000;
    end
    else
    begin
      backplane_output <= 4'(4'h1 << outRow);
      segment_output <= ram_r[outRow];
    end
  end

  // bus decode: address phase captured, write applied in data phase
  assign busRd = hsel && hready && htrans[1] && !hwrite;
  assign busWr = wrPend_r;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end
    else if (hready)
    begin
      wrPend_r <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      wrAddr_r <= haddr[7:0];
    end
  end

  // banks kept apart so one fills while the other shows
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mode_r <= lcd_ram_pkg::MODE_RST;
      inBank_r <= 1'b0;
      outBank_r <= 1'b0;
    end
    else if (busWr && (wrAddr_r == lcd_ram_pkg::ADDR_CTRL))
    begin
      mode_r <= hwdata[lcd_ram_pkg::CTRL_MODE_LSB +: 2];
      inBank_r <= hwdata[lcd_ram_pkg::CTRL_INBANK];
      outBank_r <= hwdata[lcd_ram_pkg::CTRL_OUTBANK];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      lcd_ram_pkg::ADDR_CTRL: rdMux[3:0] = {outBank_r, inBank_r, mode_r};
      lcd_ram_pkg::ADDR_PTR: rdMux[5:0] = ptr_r;
      lcd_ram_pkg::ADDR_SUB: rdMux[2:0] = subCnt_r;
      lcd_ram_pkg::ADDR_STAT:
        rdMux[9:0] = {match, hwSub, phase_r, wrRow_r, i2cState_r};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // zero-wait slave, response always okay
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (busRd)
    begin
      hrdata <= rdMux;
    end
  end

  // start must be taken from any state
  property p_start;
    @(posedge core_clk) disable iff (srst)
    startCond |=> (i2cState_r == lcd_ram_pkg::I_BITS) && (bitCnt_r == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge core_clk) disable iff (srst)
    (stopCond && !startCond) |=> (i2cState_r == lcd_ram_pkg::I_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_one_bit;
    @(posedge core_clk) disable iff (srst)
    (bitTake && !startCond && !stopCond) |=> (bitCnt_r == 4'($past(bitCnt_r) + 4'h1));
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("bit count wrong");

  property p_ack_match;
    @(posedge core_clk) disable iff (srst)
    (bitTake && lastBit) |=> (sdaOeN == !$past(match));
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("ack wrong");

  property p_ptr_tri;
    @(posedge core_clk) disable iff (srst)
    (bitTake && !busWr && (mode_r == lcd_ram_pkg::MODE_TRI) && (bitCnt_r == 4'h7) &&
     (ptr_r < lcd_ram_pkg::PTR_LAST)) |=> (ptr_r == 6'($past(ptr_r) + 6'h01));
  endproperty
  a_ptr_tri: assert property (p_ptr_tri) else $error("1:3 step wrong");

  property p_overflow;
    @(posedge core_clk) disable iff (srst)
    (bitTake && !busWr && advance && (ptr_r == lcd_ram_pkg::PTR_LAST)) |=>
      (ptr_r == 6'h00) && (subCnt_r == 3'($past(subCnt_r) + 3'h1));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow wrong");

  property p_static_bank;
    @(posedge core_clk) disable iff (srst)
    (mode_r == lcd_ram_pkg::MODE_STATIC && phase_r == 2'h0) |=>
      (backplane_output == ($past(outBank_r) ? 4'h4 : 4'h1));
  endproperty
  a_static_bank: assert property (p_static_bank) else $error("static row");

  property p_dup_bank;
    @(posedge core_clk) disable iff (srst)
    (mode_r == lcd_ram_pkg::MODE_DUP && outBank_r && phase_r <= 2'h1) |=>
      (backplane_output == 4'h4 || backplane_output == 4'h8);
  endproperty
  a_dup_bank: assert property (p_dup_bank) else $error("1:2 bank row");

  property p_quad_seq;
    @(posedge core_clk) disable iff (srst)
    (tick_r && mode_r == lcd_ram_pkg::MODE_QUAD) |=>
      (phase_r == 2'($past(phase_r) + 2'h1));
  endproperty
  a_quad_seq: assert property (p_quad_seq) else $error("1:4 sequence");

  property p_tri_wrap;
    @(posedge core_clk) disable iff (srst)
    (tick_r && mode_r == lcd_ram_pkg::MODE_TRI && phase_r == 2'h2) |=> (phase_r == 2'h0);
  endproperty
  a_tri_wrap: assert property (p_tri_wrap) else $error("1:3 sequence");
endmodule

// *** logic/lcd_ram_pkg.sv ***
// constants and types shared by the display RAM write-mapping block
package lcd_ram_pkg;
  localparam int COLS = 40;
  localparam int ROWS = 4;
  localparam logic [5:0] PTR_LAST = 6'h27;
  // drive mode codes
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_DUP = 2'h1;
  localparam logic [1:0] MODE_TRI = 2'h2;
  localparam logic [1:0] MODE_QUAD = 2'h3;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PTR = 8'h04;
  localparam logic [7:0] ADDR_SUB = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INBANK = 2;
  localparam int CTRL_OUTBANK = 3;
  // values after reset
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [2:0] SUB_RST = 3'h0;
  // multiplex phase timing
  localparam int CLK_NS = 10;
  localparam int MUX_PHASE_NS = 2400;
  localparam int MUX_PHASE_CYC = MUX_PHASE_NS / CLK_NS;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [1:0] {I_IDLE, I_BITS, I_ACK} i2c_state_t;
endpackage

// *** logic/pin_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_r <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// *** tb/i2c_master_model.sv ***
// serial link master model: paced clock line and open-drain data pull-down
`timescale 1ns/100ps
module i2c_master_model (
  // pacing clock
  input wire logic core_clk,
  // resolved data wire
  input wire logic sdaWire,
  // link clock and data pull-down
  output logic scl,
  output logic sdaLow
);
  // idle bus: clock driven high, data released, its pull-up holds it high
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // a quarter of the 160 ns link period
  task automatic qtr;
    repeat (4) @(posedge core_clk);
  endtask
  // entered only with clock and data high
  task automatic start;
    sdaLow <= 1'b0;
    qtr;
    qtr;
    sdaLow <= 1'b1;
    qtr;
    scl <= 1'b0;
  endtask
  // msb first, data moved only while the clock is low
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      qtr;
      sdaLow <= ~b[i];
      qtr;
      scl <= 1'b1;
      qtr;
      qtr;
      scl <= 1'b0;
    end
    qtr;
    sdaLow <= 1'b0;
    qtr;
    scl <= 1'b1;
    qtr;
    ack = ~sdaWire;
    qtr;
    scl <= 1'b0;
  endtask
  // data rises while clock high, leaving the bus idle
  task automatic stop;
    qtr;
    sdaLow <= 1'b1;
    qtr;
    scl <= 1'b1;
    qtr;
    sdaLow <= 1'b0;
    qtr;
  endtask
endmodule

// *** tb/lcd_ram_bank_tb.sv ***
// self-checking bench for display RAM mapping and bank selection
`timescale 1ns/100ps
module lcd_ram_bank_tb;
  logic core_clk, srst, hsel, hwrite, hreadyout, hresp, scl, sdaLow, sdaOeN, ack, ack2;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] strap;
  logic sdaOutS;
  logic [3:0] backplane;
  logic [39:0] segment, segRow;
  int mismatches, checked;
  // open-drain wire with pull-up; an undriven enable counts as released
  wire logic sdaWire = !(sdaLow || sdaOeN === 1'b0);
  always #5 core_clk = ~core_clk;
  lcd_ram_bank #(.PHASE_CYC(4)) i_lcd_ram_bank (
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOutS),
    .sdaOeN(sdaOeN), .hw_subaddr_bit0(strap[0]), .hw_subaddr_bit1(strap[1]),
    .hw_subaddr_bit2(strap[2]), .backplane_output(backplane), .segment_output(segment));
  i2c_master_model i_i2c_master_model (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl),
    .sdaLow(sdaLow));
  // compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for hready sampled high, bounded
  task automatic waitRdy;
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy;
    rd = hrdata;
  endtask
  // one whole frame of bytes; second ack kept apart
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic two);
    i_i2c_master_model.start;
    i_i2c_master_model.sendByte(b0, ack);
    if (two)
      i_i2c_master_model.sendByte(b1, ack2);
    i_i2c_master_model.stop;
  endtask
  // capture segments in the phase whose backplane bit is in the mask
  task automatic row(input logic [3:0] m);
    int n;
    n = 0;
    repeat (3) @(posedge core_clk);
    do
    begin
      @(posedge core_clk);
      n++;
    end while ((backplane & m) === 4'h0 && n < 100);
    segRow = segment;
  endtask
  task automatic tReset;
    bus(0, lcd_ram_pkg::ADDR_CTRL, 32'h0);
    chk(rd[3:0], 4'h0);
    bus(0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    chk(sdaOutS, 1'b0);
    $display("done: reset and map");
  endtask
  task automatic tStatic;
    bus(1, lcd_ram_pkg::ADDR_SUB, 32'h0);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h0);
    frame(8'hC1, 8'h00, 1'b0);
    chk(ack, 1'b1);
    bus(0, lcd_ram_pkg::ADDR_PTR, 32'h0);
    chk(rd[5:0], 6'h08);
    row(4'h1);
    chk(segRow[7:0], 8'h83);
    $display("done: static write");
  endtask
  // straps at 5: counter 5 stores, counter 4 must leave the columns alone
  task automatic tSub;
    strap <= 3'h5;
    bus(1, lcd_ram_pkg::ADDR_SUB, 32'h5);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h8);
    frame(8'hFF, 8'h00, 1'b0);
    chk(ack, 1'b1);
    bus(1, lcd_ram_pkg::ADDR_SUB, 32'h4);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h8);
    frame(8'h00, 8'h00, 1'b0);
    chk(ack, 1'b0);
    bus(0, lcd_ram_pkg::ADDR_PTR, 32'h0);
    chk(rd[5:0], 6'h10);
    row(4'h1);
    chk(segRow[15:8], 8'hFF);
    strap <= 3'h0;
    bus(1, lcd_ram_pkg::ADDR_SUB, 32'h0);
    $display("done: subaddress");
  endtask
  // write bank 1 while bank 0 shows, then switch the output bank
  task automatic tBank;
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'h5);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h0);
    frame(8'h96, 8'h00, 1'b0);
    row(4'h5);
    chk(segRow[7:0], 8'h83);
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'hD);
    row(4'h5);
    chk(segRow[3:0], 4'h9);
    row(4'hA);
    chk(segRow[3:0], 4'h6);
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'h8);
    row(4'h5);
    chk(segRow[3:0], 4'h9);
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'hB);
    row(4'h1);
    chk(segRow[7:0], 8'h83);
    $display("done: bank switching");
  endtask
  // standard 1:3 write, then rewrite from the third column
  task automatic tTri;
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'h2);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h0);
    frame(8'hE5, 8'h00, 1'b0);
    row(4'h4);
    chk(segRow[2:0], 3'h3);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h2);
    frame(8'hFA, 8'h00, 1'b0);
    bus(0, lcd_ram_pkg::ADDR_PTR, 32'h0);
    chk(rd[5:0], 6'h05);
    row(4'h1);
    chk(segRow[4:0], 5'h1D);
    row(4'h2);
    chk(segRow[4:0], 5'h0D);
    row(4'h4);
    chk(segRow[3:0], 4'h7);
    $display("done: 1:3 rewrite");
  endtask
  // 1:4 across the last column: next byte belongs to the next device
  task automatic tOver;
    bus(1, lcd_ram_pkg::ADDR_CTRL, 32'h3);
    bus(1, lcd_ram_pkg::ADDR_PTR, 32'h26);
    frame(8'hF0, 8'h3C, 1'b1);
    chk(ack, 1'b1);
    chk(ack2, 1'b0);
    bus(0, lcd_ram_pkg::ADDR_SUB, 32'h0);
    chk(rd[2:0], 3'h1);
    row(4'h8);
    chk(segRow[39:38], 2'h1);
    row(4'h1);
    chk(segRow[1:0], 2'h1);
    $display("done: overflow");
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    strap = 3'h0;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    tReset;
    tStatic;
    tSub;
    tBank;
    tTri;
    tOver;
    complete_run;
  end
  // hang guard, far beyond the roughly 1.6k cycles the tests need
  initial
  begin
    #300000;
    mismatches++;
    complete_run;
  end
endmodule
